// *** rtl/bra_pkg.sv ***
package bra_pkg;
    localparam int PTR_W = 16;
    localparam int NUM_AUX = 8;
    localparam int SEL_W = 3;
    localparam int DATA_W = 32;
    localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
    localparam logic MODE_DSP = 1'b0;

    typedef enum logic [1:0] {
        BRA_OP_NONE,
        BRA_OP_LOAD,
        BRA_OP_RC_ADD,
        BRA_OP_RC_SUB
    } bra_op_e;

    // Reverse both operands, add or subtract, reverse back
    function automatic logic [PTR_W-1:0] bra_rc_add(
        input logic [PTR_W-1:0] a,
        input logic [PTR_W-1:0] b,
        input logic sub
    );
        logic [PTR_W-1:0] ra;
        logic [PTR_W-1:0] rb;
        logic [PTR_W-1:0] rs;
        logic [PTR_W-1:0] ro;
        ra = {<<{a}};
        rb = {<<{b}};
        if (sub)
        begin
            rs = ra - rb;
        end
        else
        begin
            rs = ra + rb;
        end
        ro = {<<{rs}};
        return ro;
    endfunction
endpackage

// *** rtl/bra_rc_unit.sv ***
`timescale 1ns/1ns
module bra_rc_unit (
    input wire logic [bra_pkg::PTR_W-1:0] i_ptr,
    input wire logic [bra_pkg::PTR_W-1:0] i_index,
    input wire logic i_sub,
    output logic [bra_pkg::PTR_W-1:0] o_next
);
    // Carry ripples MSB toward LSB; carry out of bit 0 is lost
    always_comb
    begin
        o_next = bra_pkg::bra_rc_add(i_ptr, i_index,
            i_sub);
    end
endmodule // bra_rc_unit

// *** rtl/bra_addr_gen.sv ***
// Contract
// - No reversed-carry update while control mode is selected.
// - Reversed-carry update ripples carry from MSB toward LSB.
// - Pointers are 16 bits; arrays stay inside one 64K region.
// - Off-place reorder sustains 2 cycles per element.
// - Element moved as double word, stored via reversed-carry pointer.
// - Subtract form: access uses old pointer, then subtract.
// - Add form: access uses old pointer, then add.
// - Any of eight pointers is base; index reg is fixed.
`timescale 1ns/1ns
module bra_addr_gen (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_addr_mode,
    input wire bra_pkg::bra_op_e i_op,
    input wire logic [bra_pkg::SEL_W-1:0] i_sel,
    input wire logic [bra_pkg::PTR_W-1:0] i_load_val,
    input wire logic i_index_we,
    input wire logic [bra_pkg::PTR_W-1:0] i_index_val,
    output logic [bra_pkg::PTR_W-1:0] o_addr,
    output logic o_addr_vld,
    output logic o_mode_err,
    output logic [bra_pkg::PTR_W-1:0] o_index
);
    logic [bra_pkg::PTR_W-1:0] aux_pointer_reg_ff [bra_pkg::NUM_AUX];
    logic [bra_pkg::PTR_W-1:0] reverse_index_reg_ff;
    logic [bra_pkg::PTR_W-1:0] nxt_ptr;
    logic rc_op;
    logic rc_ok;

    assign rc_op = (i_op == bra_pkg::BRA_OP_RC_ADD) ||
        (i_op == bra_pkg::BRA_OP_RC_SUB);
    // Control mode blocks the update rather than doing a plain add
    assign rc_ok = rc_op && (i_addr_mode == bra_pkg::MODE_DSP);

    bra_rc_unit u_rc (
        .i_ptr(aux_pointer_reg_ff[i_sel]),
        .i_index(reverse_index_reg_ff),
        .i_sub(i_op == bra_pkg::BRA_OP_RC_SUB),
        .o_next(nxt_ptr)
    );

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            reverse_index_reg_ff <= bra_pkg::PTR_RST;
        end
        else if (i_index_we)
        begin
            reverse_index_reg_ff <= i_index_val;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            for (int k = 0; k < bra_pkg::NUM_AUX; k++)
            begin
                aux_pointer_reg_ff[k] <= bra_pkg::PTR_RST;
            end
        end
        else if (i_op == bra_pkg::BRA_OP_LOAD)
        begin
            aux_pointer_reg_ff[i_sel] <= i_load_val;
        end
        else if (rc_ok)
        begin
            // Post-modify, one update per cycle
            aux_pointer_reg_ff[i_sel] <= nxt_ptr;
        end
    end

    // Access address is the pointer before modification
    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_addr <= bra_pkg::PTR_RST;
            o_addr_vld <= 1'b0;
            o_mode_err <= 1'b0;
        end
        else
        begin
            o_addr <= aux_pointer_reg_ff[i_sel];
            o_addr_vld <= rc_ok;
            o_mode_err <= rc_op && !rc_ok;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_index <= bra_pkg::PTR_RST;
        end
        else
        begin
            o_index <= i_index_we ? i_index_val : reverse_index_reg_ff;
        end
    end

    // Helper: mask of bits above the index's top set bit
    logic [bra_pkg::PTR_W-1:0] hi_mask;
    always_comb
    begin
        hi_mask = '1;
        for (int k = 0; k < bra_pkg::PTR_W; k++)
        begin
            if (reverse_index_reg_ff[k])
            begin
                hi_mask = '1 << (k + 1);
            end
        end
    end

    // Independent model: ripple from the top bit down, one bit a step,
    // so a slip in the unit's reverse-add-reverse form cannot hide here
    function automatic logic [bra_pkg::PTR_W-1:0] rc_ref(
        input logic [bra_pkg::PTR_W-1:0] ptr,
        input logic [bra_pkg::PTR_W-1:0] idx,
        input logic sub
    );
        logic [bra_pkg::PTR_W-1:0] res;
        logic cy;
        res = '0;
        cy = 1'b0;
        for (int k = bra_pkg::PTR_W - 1; k >= 0; k--)
        begin
            res[k] = ptr[k] ^ idx[k] ^ cy;
            if (sub)
            begin
                cy = (!ptr[k] && idx[k]) || (!(ptr[k] ^ idx[k]) && cy);
            end
            else
            begin
                cy = (ptr[k] && idx[k]) || ((ptr[k] ^ idx[k]) && cy);
            end
        end
        // Carry or borrow out of bit 0 is simply dropped
        return res;
    endfunction

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);

    rc_addr_old_a: assert property (rc_ok |=> o_addr_vld &&
        o_addr == $past(aux_pointer_reg_ff[i_sel]))
        else $error("Access address is not the old pointer");

    rc_ctrl_block_a: assert property (
        rc_op && i_addr_mode != bra_pkg::MODE_DSP && i_op != bra_pkg::BRA_OP_LOAD
        |=> aux_pointer_reg_ff[$past(i_sel)] ==
            $past(aux_pointer_reg_ff[i_sel]) && o_mode_err && !o_addr_vld)
        else $error("Reversed-carry update in control mode");

    rc_add_val_a: assert property (
        rc_ok && i_op == bra_pkg::BRA_OP_RC_ADD |=>
        aux_pointer_reg_ff[$past(i_sel)] == $past(rc_ref(
            aux_pointer_reg_ff[i_sel], reverse_index_reg_ff, 1'b0)))
        else $error("Reversed-carry add wrong");

    rc_sub_val_a: assert property (
        rc_ok && i_op == bra_pkg::BRA_OP_RC_SUB |=>
        aux_pointer_reg_ff[$past(i_sel)] == $past(rc_ref(
            aux_pointer_reg_ff[i_sel], reverse_index_reg_ff, 1'b1)))
        else $error("Reversed-carry subtract wrong");

    rc_high_keep_a: assert property (
        rc_ok |=> ((aux_pointer_reg_ff[$past(i_sel)] ^
            $past(aux_pointer_reg_ff[i_sel])) & $past(hi_mask)) == '0)
        else $error("High pointer bits changed");

    rc_wrap_a: assert property (
        rc_ok && i_op == bra_pkg::BRA_OP_RC_ADD &&
        reverse_index_reg_ff == 16'h0001 && aux_pointer_reg_ff[i_sel][0]
        |=> aux_pointer_reg_ff[$past(i_sel)][0] == 1'b0 &&
            aux_pointer_reg_ff[$past(i_sel)][15:1] ==
            $past(aux_pointer_reg_ff[i_sel][15:1]))
        else $error("Carry out of LSB not discarded");

    // Second of two back-to-back ops must see the first one's result
    rc_rate_a: assert property (
        rc_ok ##1 (rc_ok && i_sel == $past(i_sel)) |=>
        o_addr == $past(rc_ref(aux_pointer_reg_ff[i_sel],
            reverse_index_reg_ff, i_op == bra_pkg::BRA_OP_RC_SUB), 2))
        else $error("Back-to-back updates not sustained");

    rc_index_fix_a: assert property (
        rc_ok && !i_index_we |=> reverse_index_reg_ff ==
            $past(reverse_index_reg_ff))
        else $error("Index changed by pointer update");

    load_write_a: assert property (
        i_op == bra_pkg::BRA_OP_LOAD |=>
        aux_pointer_reg_ff[$past(i_sel)] == $past(i_load_val))
        else $error("Pointer load lost");

    index_write_a: assert property (
        i_index_we |=> reverse_index_reg_ff == $past(i_index_val) &&
            o_index == $past(i_index_val))
        else $error("Index write lost");

    // Output strobes only follow the op that caused them
    vld_cause_a: assert property (
        o_addr_vld |-> $past(rc_op) &&
            $past(i_addr_mode) == bra_pkg::MODE_DSP)
        else $error("Valid strobe without accepted update");

    err_cause_a: assert property (
        o_mode_err |-> $past(rc_op) &&
            $past(i_addr_mode) != bra_pkg::MODE_DSP)
        else $error("Mode error without refused update");

    idle_keep_a: assert property (
        i_op == bra_pkg::BRA_OP_NONE |=> aux_pointer_reg_ff[$past(i_sel)] ==
            $past(aux_pointer_reg_ff[i_sel]))
        else $error("Pointer moved without an op");

    // Main scenarios: both forms, refusal, long runs, carry off bit 0
    cov_add_c: cover property (rc_ok && i_op == bra_pkg::BRA_OP_RC_ADD);
    cov_sub_c: cover property (rc_ok && i_op == bra_pkg::BRA_OP_RC_SUB);
    cov_err_c: cover property (o_mode_err);
    cov_run_c: cover property (rc_ok [*4]);
    cov_wrap_c: cover property (rc_ok && reverse_index_reg_ff[0] &&
        aux_pointer_reg_ff[i_sel][0]);
endmodule // bra_addr_gen

// *** tb/bra_sw_setup.sv ***
`timescale 1ns/1ns
// Software side: mode bit and vector setup for a reorder of 2^i_log_n points
module bra_sw_setup (
    input wire logic i_split,
    input wire logic [3:0] i_log_n,
    output logic o_mode,
    output logic [15:0] o_index,
    output logic [15:0] o_base
);
    assign o_mode = 1'b0;
    assign o_index = i_split ? (16'h0001 << (i_log_n - 4'h1))
                             : (16'h0001 << i_log_n);
    // Base stays in one 16-bit region, low bits cleared
    assign o_base = 16'h7a3f &
        (16'hffff << (i_log_n + 4'(!i_split)));
endmodule // bra_sw_setup

// *** tb/tb.sv ***
`timescale 1ns/1ns
module tb;
    logic i_mclk = 1'b0;
    logic i_rst_b = 1'b0;
    logic bad = 1'b0;
    logic split = 1'b0;
    logic [3:0] log_n = 4'h3;
    logic i_index_we = 1'b0;
    logic [2:0] i_sel = 3'h0;
    logic [15:0] i_load_val = 16'h0000;
    logic sw_mode;
    logic o_addr_vld;
    logic o_mode_err;
    logic [15:0] sw_index;
    logic [15:0] sw_base;
    logic [15:0] o_addr;
    logic [15:0] o_index;
    bra_pkg::bra_op_e i_op = bra_pkg::BRA_OP_NONE;
    int n_fail = 0;
    int compares = 0;
    always #25 i_mclk = ~i_mclk;
    bra_sw_setup u_bra_sw_setup (.i_split(split), .i_log_n(log_n),
        .o_mode(sw_mode), .o_index(sw_index), .o_base(sw_base));
    bra_addr_gen u_bra_addr_gen (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
        .i_addr_mode(sw_mode | bad), .i_op(i_op), .i_sel(i_sel),
        .i_load_val(i_load_val), .i_index_we(i_index_we),
        .i_index_val(sw_index), .o_addr(o_addr), .o_addr_vld(o_addr_vld),
        .o_mode_err(o_mode_err), .o_index(o_index));
    function automatic logic [15:0] rev(input logic [3:0] k);
        return {12'h7a3, k[0], k[1], k[2], k[3]};
    endfunction
    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task step(input bra_pkg::bra_op_e op, input logic [2:0] sel);
        i_op = op;
        i_sel = sel;
        @(negedge i_mclk);
    endtask
    // Index and base pointer written in one cycle
    task setup(input logic [2:0] sel, input logic [15:0] exp_idx);
        i_index_we = 1'b1;
        i_load_val = sw_base;
        step(bra_pkg::BRA_OP_LOAD, sel);
        i_index_we = 1'b0;
        chk(o_index, exp_idx);
    endtask
    // Past 16 steps the low nibble wraps, upper bits stay
    task reorder_add();
        setup(3'h2, 16'h0008);
        for (int k = 0; k < 17; k++)
        begin
            step(bra_pkg::BRA_OP_RC_ADD, 3'h2);
            chk(o_addr, rev(4'(k)));
            chk({15'h0000, o_addr_vld}, 16'h0001);
        end
    endtask
    task reorder_sub();
        setup(3'h5, 16'h0008);
        for (int k = 0; k < 4; k++)
        begin
            step(bra_pkg::BRA_OP_RC_SUB, 3'h5);
            chk(o_addr, rev(4'(16 - k)));
        end
    endtask
    task refuse();
        bad = 1'b1;
        step(bra_pkg::BRA_OP_RC_ADD, 3'h5);
        chk({14'h0000, o_mode_err, o_addr_vld}, 16'h0002);
        bad = 1'b0;
        step(bra_pkg::BRA_OP_RC_ADD, 3'h5);
        chk(o_addr, rev(4'hc));
        chk({14'h0000, o_mode_err, o_addr_vld}, 16'h0001);
    endtask
    // Split layout: index 2^(n-1), three-bit reversed count over 7a38
    task split_reorder();
        split = 1'b1;
        step(bra_pkg::BRA_OP_NONE, 3'h3);
        setup(3'h3, 16'h0004);
        for (int k = 0; k < 9; k++)
        begin
            step(bra_pkg::BRA_OP_RC_ADD, 3'h3);
            chk(o_addr, {13'h0f47, k[0], k[1], k[2]});
        end
    endtask
    // Index of one: carry off bit 0 vanishes, pointer only toggles
    task lsb_wrap();
        log_n = 4'h1;
        step(bra_pkg::BRA_OP_NONE, 3'h7);
        setup(3'h7, 16'h0001);
        for (int k = 0; k < 4; k++)
        begin
            step(bra_pkg::BRA_OP_RC_ADD, 3'h7);
            chk(o_addr, {15'h3d1f, k[0]});
        end
    endtask
    // Mid-run reset clears pointers and index; zero index moves nothing
    task mid_reset();
        i_rst_b = 1'b0;
        step(bra_pkg::BRA_OP_RC_ADD, 3'h7);
        chk({14'h0000, o_mode_err, o_addr_vld}, 16'h0000);
        chk(o_addr, bra_pkg::PTR_RST);
        chk(o_index, bra_pkg::PTR_RST);
        i_rst_b = 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            step(bra_pkg::BRA_OP_RC_ADD, 3'h7);
            chk(o_addr, bra_pkg::PTR_RST);
        end
        chk({15'h0000, o_addr_vld}, 16'h0001);
    endtask
    task report_and_stop();
        if (n_fail == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #100000;
        n_fail++;
        report_and_stop();
    end
    initial
    begin
        repeat (3) @(negedge i_mclk);
        i_rst_b = 1'b1;
        reorder_add();
        reorder_sub();
        refuse();
        split_reorder();
        lsb_wrap();
        mid_reset();
        step(bra_pkg::BRA_OP_NONE, 3'h0);
        report_and_stop();
    end
endmodule // tb
